// ===== core/toc_consts.svh
/*
 * Offsets, bit positions, reset values and fixed counter values of the
 * timer output compare block.
 * Assumes an 8-bit register port with a 4-bit byte address.
 */
`ifndef TOC_CONSTS_SVH
`define TOC_CONSTS_SVH

// Register byte offsets
`define TOC_OFS_CTRL_ONE   4'h0
`define TOC_OFS_CTRL_TWO   4'h1
`define TOC_OFS_STATUS     4'h2
`define TOC_OFS_CMP1_HI    4'h3
`define TOC_OFS_CMP1_LO    4'h4
`define TOC_OFS_CMP2_HI    4'h5
`define TOC_OFS_CMP2_LO    4'h6
`define TOC_OFS_CAP1_HI    4'h7
`define TOC_OFS_CAP1_LO    4'h8
`define TOC_OFS_CNT_HI     4'h9
`define TOC_OFS_CNT_LO     4'ha

// Control one bits
`define TOC_C1_OLVL1       0
`define TOC_C1_OLVL2       1
`define TOC_C1_EDGE        2
`define TOC_C1_FORCE1      3
`define TOC_C1_FORCE2      4
`define TOC_C1_TOIE        5
`define TOC_C1_CAPTURE_IRQ_ENABLE        6
`define TOC_C1_COMPARE_IRQ_ENABLE        7

// Control two bits
`define TOC_C2_CC_LO       0
`define TOC_C2_CC_HI       1
`define TOC_C2_OPM         2
`define TOC_C2_PWM         3
`define TOC_C2_PEN1        4
`define TOC_C2_PEN2        5

// Status bits
`define TOC_ST_OCF1        0
`define TOC_ST_OCF2        1
`define TOC_ST_CAPTURE_FLAG_ONE        2
`define TOC_ST_TOF         3

// Reset and load values
`define TOC_CMP_RESET      16'h8000
`define TOC_CNT_RESET      16'hfffc
`define TOC_CAP_OPM        16'hfffd
`define TOC_CNT_TOP        16'hffff

// Prescaler masks: divide by 2, 4, 8
`define TOC_DIV2_MASK      3'h1
`define TOC_DIV4_MASK      3'h3
`define TOC_DIV8_MASK      3'h7

`endif

// ===== core/toc_pkg.sv
/*
 * Types of the timer output compare block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package toc_pkg;
   // Operating mode of the timer
   typedef enum logic [1:0] {
      toc_mode_normal = 2'b00,
      toc_mode_opm    = 2'b01,
      toc_mode_pwm    = 2'b10
   } toc_mode_t;

   // Timer clock source
   typedef enum logic [1:0] {
      toc_clk_div4 = 2'b00,
      toc_clk_div2 = 2'b01,
      toc_clk_div8 = 2'b10,
      toc_clk_ext  = 2'b11
   } toc_clk_sel_t;
endpackage

// ===== core/toc_timer_compare.sv
/*
 * Output compare unit of a 16-bit free running timer: two compare
 * channels, forced output level, one pulse mode fed by capture input 1,
 * shared timer interrupt request.
 * Assumes all inputs synchronous to sys_clk and an 8-bit register port
 * with read data returned one cycle after the read strobe.
 */
`include "toc_consts.svh"

module toc_timer_compare #(
   parameter int CNT_W = 16                   // Counter width
) (
   input  wire logic       sys_clk,           // System clock
   input  wire logic       rst_b,             // Synchronous reset
   input  wire logic [3:0] reg_addr,          // Register byte address
   input  wire logic [7:0] reg_wdata,         // Write data
   input  wire logic       reg_wr,            // Write strobe
   input  wire logic       reg_rd,            // Read strobe
   output logic      [7:0] reg_rdata,         // Read data, next cycle
   input  wire logic       cpu_irq_mask,      // CPU interrupt mask bit
   input  wire logic       ext_clk,           // External timer clock
   input  wire logic       capture_input_one, // Capture / trigger input
   output logic            timer_irq,         // Timer interrupt request
   output logic            compare_output_pin1,    // Pin 1 level
   output logic            compare_output_pin1_oe, // Pin 1 driven
   output logic            compare_output_pin2,    // Pin 2 level
   output logic            compare_output_pin2_oe  // Pin 2 driven
);

   // Refuse widths the byte map cannot serve
   if (CNT_W != 16) begin : g_bad_width
      $error("toc_timer_compare: CNT_W must be 16");
   end

   // Software registers
   logic [7:0]       ctrl_one_ff;             // Levels, edge, enables
   logic [7:0]       ctrl_two_ff;             // Clock, modes, pin enables
   logic [CNT_W-1:0] compare_value_one_ff;    // Compare value 1
   logic [CNT_W-1:0] compare_value_two_ff;    // Compare value 2
   logic [CNT_W-1:0] capture_value_one_ff;    // Capture value 1
   logic [CNT_W-1:0] cnt_ff;                  // Free running counter
   logic [2:0]       presc_ff;                // Prescaler
   logic             ext_q_ff;                // External clock history
   logic             cap_q_ff;                // Capture input history
   logic             cnt_new_ff;              // Counter took a new value
   logic [1:0]       inhibit_ff;              // Compare inhibit per channel
   logic [3:0]       flag_ff;                 // Status flags
   logic [3:0]       arm_ff;                  // First clear step seen
   logic             irq_ff;                  // Registered request
   logic             pin1_ff;                 // Pin 1 latch
   logic             pin2_ff;                 // Pin 2 latch
   logic [7:0]       rdata_ff;                // Read data register

   toc_pkg::toc_mode_t    mode;               // Decoded mode
   toc_pkg::toc_clk_sel_t clk_sel;            // Decoded clock source
   logic [2:0]            div_mask;           // Prescaler mask
   logic                  tick;               // Timer count enable
   logic                  cap_edge;           // Valid capture edge
   logic                  trig;               // One pulse trigger
   logic                  match1;             // Channel 1 match
   logic                  match2;             // Channel 2 match
   logic                  wr_c1;              // Control one write
   logic                  force1;             // Effective force ch 1
   logic                  force2;             // Effective force ch 2
   logic                  acc_lo1;            // Low compare 1 access
   logic                  acc_lo2;            // Low compare 2 access
   logic                  acc_cap_lo;         // Low capture access
   logic                  acc_cnt_lo;         // Low counter access
   logic [3:0]            flag_set;           // Hardware flag sets
   logic [3:0]            flag_clr;           // Software flag clears
   logic                  nxt_irq;            // Combined request

   // Mode decode, PWM wins over one pulse
   always_comb begin
      case (ctrl_two_ff[`TOC_C2_PWM:`TOC_C2_OPM])
         2'b01:   mode = toc_pkg::toc_mode_opm;
         2'b10,
         2'b11:   mode = toc_pkg::toc_mode_pwm;
         default: mode = toc_pkg::toc_mode_normal;
      endcase
   end

   // Clock source and divider mask
   always_comb begin
      clk_sel = toc_pkg::toc_clk_sel_t'(ctrl_two_ff[`TOC_C2_CC_HI:`TOC_C2_CC_LO]);
      case (clk_sel)
         toc_pkg::toc_clk_div2: div_mask = `TOC_DIV2_MASK;
         toc_pkg::toc_clk_div8: div_mask = `TOC_DIV8_MASK;
         default:               div_mask = `TOC_DIV4_MASK;
      endcase
   end

   // Count enable from prescaler or external rising edge
   assign tick = (clk_sel == toc_pkg::toc_clk_ext) ? (ext_clk & ~ext_q_ff)
                 : ((presc_ff & div_mask) == div_mask);

   // Capture input edge, polarity by edge select
   assign cap_edge = ctrl_one_ff[`TOC_C1_EDGE] ? (capture_input_one & ~cap_q_ff)
                     : (~capture_input_one & cap_q_ff);
   assign trig = cap_edge && (mode == toc_pkg::toc_mode_opm);

   // Matches only on the cycle after the counter changed
   assign match1 = cnt_new_ff && !inhibit_ff[0] && (cnt_ff == compare_value_one_ff);
   assign match2 = cnt_new_ff && !inhibit_ff[1] && (cnt_ff == compare_value_two_ff);

   // Register access decode
   assign wr_c1      = reg_wr && (reg_addr == `TOC_OFS_CTRL_ONE);
   assign force1     = wr_c1 && reg_wdata[`TOC_C1_FORCE1]
                       && (mode == toc_pkg::toc_mode_normal);
   assign force2     = wr_c1 && reg_wdata[`TOC_C1_FORCE2]
                       && (mode == toc_pkg::toc_mode_normal);
   assign acc_lo1    = (reg_wr | reg_rd) && (reg_addr == `TOC_OFS_CMP1_LO);
   assign acc_lo2    = (reg_wr | reg_rd) && (reg_addr == `TOC_OFS_CMP2_LO);
   assign acc_cap_lo = (reg_wr | reg_rd) && (reg_addr == `TOC_OFS_CAP1_LO);
   assign acc_cnt_lo = (reg_wr | reg_rd) && (reg_addr == `TOC_OFS_CNT_LO);

   // Prescaler and edge histories
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         presc_ff <= 3'h0;
         ext_q_ff <= 1'b0;
         cap_q_ff <= 1'b0;
      end else begin
         presc_ff <= presc_ff + 3'h1;
         ext_q_ff <= ext_clk;
         cap_q_ff <= capture_input_one;
      end
   end

   // Counter: trigger reload, else step on tick
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cnt_ff     <= `TOC_CNT_RESET;
         cnt_new_ff <= 1'b0;
      end else begin
         cnt_new_ff <= tick | trig;
         if (trig) begin
            cnt_ff <= `TOC_CNT_RESET;
         end else if (tick) begin
            cnt_ff <= cnt_ff + 16'h0001;
         end
      end
   end

   // Control registers; force bits are actions and are not stored
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ctrl_one_ff <= 8'h00;
         ctrl_two_ff <= 8'h00;
      end else begin
         if (wr_c1) begin
            ctrl_one_ff <= reg_wdata & 8'he7;
         end
         if (reg_wr && (reg_addr == `TOC_OFS_CTRL_TWO)) begin
            ctrl_two_ff <= reg_wdata & 8'h3f;
         end
      end
   end

   // Compare values, written only by software
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         compare_value_one_ff <= `TOC_CMP_RESET;
         compare_value_two_ff <= `TOC_CMP_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `TOC_OFS_CMP1_HI: compare_value_one_ff[15:8] <= reg_wdata;
            `TOC_OFS_CMP1_LO: compare_value_one_ff[7:0]  <= reg_wdata;
            `TOC_OFS_CMP2_HI: compare_value_two_ff[15:8] <= reg_wdata;
            `TOC_OFS_CMP2_LO: compare_value_two_ff[7:0]  <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Compare inhibit from high write until low write
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         inhibit_ff <= 2'b00;
      end else if (reg_wr) begin
         case (reg_addr)
            `TOC_OFS_CMP1_HI: inhibit_ff[0] <= 1'b1;
            `TOC_OFS_CMP1_LO: inhibit_ff[0] <= 1'b0;
            `TOC_OFS_CMP2_HI: inhibit_ff[1] <= 1'b1;
            `TOC_OFS_CMP2_LO: inhibit_ff[1] <= 1'b0;
            default: ;
         endcase
      end
   end

   // Capture value: counter on edge in normal mode, fixed value on trigger
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         capture_value_one_ff <= 16'h0000;
      end else if (trig) begin
         capture_value_one_ff <= `TOC_CAP_OPM;
      end else if (cap_edge && (mode == toc_pkg::toc_mode_normal)) begin
         capture_value_one_ff <= cnt_ff;
      end
   end

   // Flag sets and second clear steps
   always_comb begin
      flag_set = 4'h0;
      flag_set[`TOC_ST_OCF1] = match1 && (mode == toc_pkg::toc_mode_normal);
      flag_set[`TOC_ST_OCF2] = match2 && (mode != toc_pkg::toc_mode_pwm);
      flag_set[`TOC_ST_CAPTURE_FLAG_ONE] = cap_edge && (mode != toc_pkg::toc_mode_pwm);
      flag_set[`TOC_ST_TOF]  = tick && !trig && (cnt_ff == `TOC_CNT_TOP);
      flag_clr = {acc_cnt_lo, acc_cap_lo, acc_lo2, acc_lo1} & arm_ff;
   end

   // Flags: set wins over clear; status read arms the clear
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         flag_ff <= 4'h0;
         arm_ff  <= 4'h0;
      end else begin
         flag_ff <= flag_set | (flag_ff & ~flag_clr);
         if (reg_rd && (reg_addr == `TOC_OFS_STATUS)) begin
            arm_ff <= flag_ff;
         end else begin
            arm_ff <= arm_ff & flag_ff & ~flag_clr;
         end
      end
   end

   // Pin 1 latch: trigger, then match, then force
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pin1_ff <= 1'b0;
      end else if (trig) begin
         pin1_ff <= ctrl_one_ff[`TOC_C1_OLVL2];
      end else if (match1 && (mode == toc_pkg::toc_mode_opm)) begin
         pin1_ff <= ctrl_one_ff[`TOC_C1_OLVL1];
      end else if (match1 && (mode == toc_pkg::toc_mode_normal)
                   && ctrl_two_ff[`TOC_C2_PEN1]) begin
         pin1_ff <= ctrl_one_ff[`TOC_C1_OLVL1];
      end else if (force1 && ctrl_two_ff[`TOC_C2_PEN1]) begin
         pin1_ff <= reg_wdata[`TOC_C1_OLVL1];
      end
   end

   // Pin 2 latch: match or force in normal mode only
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pin2_ff <= 1'b0;
      end else if (match2 && (mode == toc_pkg::toc_mode_normal)
                   && ctrl_two_ff[`TOC_C2_PEN2]) begin
         pin2_ff <= ctrl_one_ff[`TOC_C1_OLVL2];
      end else if (force2 && ctrl_two_ff[`TOC_C2_PEN2]) begin
         pin2_ff <= reg_wdata[`TOC_C1_OLVL2];
      end
   end

   // Shared request: each flag by its enable, then the CPU mask
   assign nxt_irq = !cpu_irq_mask && (
      ((flag_ff[`TOC_ST_OCF1] | flag_ff[`TOC_ST_OCF2]) & ctrl_one_ff[`TOC_C1_COMPARE_IRQ_ENABLE])
      | (flag_ff[`TOC_ST_CAPTURE_FLAG_ONE] & ctrl_one_ff[`TOC_C1_CAPTURE_IRQ_ENABLE])
      | (flag_ff[`TOC_ST_TOF] & ctrl_one_ff[`TOC_C1_TOIE]));

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `TOC_OFS_CTRL_ONE: rdata_ff <= ctrl_one_ff;
            `TOC_OFS_CTRL_TWO: rdata_ff <= ctrl_two_ff;
            `TOC_OFS_STATUS:   rdata_ff <= {4'h0, flag_ff};
            `TOC_OFS_CMP1_HI:  rdata_ff <= compare_value_one_ff[15:8];
            `TOC_OFS_CMP1_LO:  rdata_ff <= compare_value_one_ff[7:0];
            `TOC_OFS_CMP2_HI:  rdata_ff <= compare_value_two_ff[15:8];
            `TOC_OFS_CMP2_LO:  rdata_ff <= compare_value_two_ff[7:0];
            `TOC_OFS_CAP1_HI:  rdata_ff <= capture_value_one_ff[15:8];
            `TOC_OFS_CAP1_LO:  rdata_ff <= capture_value_one_ff[7:0];
            `TOC_OFS_CNT_HI:   rdata_ff <= cnt_ff[15:8];
            `TOC_OFS_CNT_LO:   rdata_ff <= cnt_ff[7:0];
            default:           rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   // Outputs
   assign reg_rdata              = rdata_ff;
   assign timer_irq              = irq_ff;
   assign compare_output_pin1    = pin1_ff;
   assign compare_output_pin2    = pin2_ff;
   assign compare_output_pin1_oe = ctrl_two_ff[`TOC_C2_PEN1];
   assign compare_output_pin2_oe = ctrl_two_ff[`TOC_C2_PEN2];

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   property p_reset_vals;
      !$past(rst_b) |-> compare_value_one_ff == 16'h8000
         && compare_value_two_ff == 16'h8000 && !pin1_ff && !pin2_ff;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

   property p_match_one;
      (match1 && mode == toc_pkg::toc_mode_normal && ctrl_two_ff[4] && !trig)
         |=> flag_ff[0] && pin1_ff == $past(ctrl_one_ff[0]);
   endproperty
   a_match_one: assert property (p_match_one) else $error("match 1 not acted on");

   property p_inhibit;
      (inhibit_ff[0] && !flag_ff[0]) |=> !flag_ff[0];
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("flag set while inhibited");

   property p_clear_needs_arm;
      (flag_ff[0] && !arm_ff[0]) |=> flag_ff[0];
   endproperty
   a_clear_needs_arm: assert property (p_clear_needs_arm) else $error("flag cleared early");

   property p_irq_masked;
      cpu_irq_mask |=> !timer_irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("request while masked");

   property p_trigger;
      trig |=> cnt_ff == 16'hfffc && capture_value_one_ff == 16'hfffd
         && flag_ff[2] && pin1_ff == $past(ctrl_one_ff[1]);
   endproperty
   a_trigger: assert property (p_trigger) else $error("trigger effects wrong");

   property p_opm_no_flag1;
      (mode == toc_pkg::toc_mode_opm && !flag_ff[0]) |=> !flag_ff[0];
   endproperty
   a_opm_no_flag1: assert property (p_opm_no_flag1) else $error("flag 1 set in pulse mode");

   property p_force;
      (force1 && ctrl_two_ff[4] && !match1 && !flag_ff[0])
         |=> pin1_ff == $past(reg_wdata[0]) && !flag_ff[0];
   endproperty
   a_force: assert property (p_force) else $error("force wrong");

endmodule // toc_timer_compare

// ===== testbench/testbench.sv
/*
 * Self-checking bench of the timer output compare block: reset values,
 * match timing per clock source, force, interlock, flag clearing,
 * interrupt masking and one pulse mode.
 * Assumes toc_consts.svh on the include path and the register map there.
 */
`include "toc_consts.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int LIMIT = 20000;         // Cycle ceiling of the run

   logic       sys_clk;                  // 20 MHz clock
   logic       rst_b;                    // Reset, active low
   logic [3:0] reg_addr;                 // Register address
   logic [7:0] reg_wdata;                // Write data
   logic       reg_wr;                   // Write strobe
   logic       reg_rd;                   // Read strobe
   logic [7:0] reg_rdata;                // Read data
   logic       cpu_irq_mask;             // CPU mask bit
   logic       ext_clk_in;               // External timer clock
   logic       cap_in;                   // Trigger input
   logic       timer_irq;                // Interrupt request
   logic       p1_o, p1_oe, p2_o, p2_oe; // Compare pins
   logic [2:0] ext_div;                  // External clock divider
   int         cyc_cnt;                  // Cycle counter
   int         error_cnt;                // Mismatches
   int         num_checks;               // Comparisons

   toc_timer_compare uut (
      .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cpu_irq_mask(cpu_irq_mask),
      .ext_clk(ext_clk_in), .capture_input_one(cap_in),
      .timer_irq(timer_irq), .compare_output_pin1(p1_o),
      .compare_output_pin1_oe(p1_oe), .compare_output_pin2(p2_o),
      .compare_output_pin2_oe(p2_oe));

   // Clock generator
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // External clock: rising edge every 10 cycles, plus hang limit
   always @(posedge sys_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      ext_div <= (ext_div == 3'h4) ? 3'h0 : ext_div + 3'h1;
      if (ext_div == 3'h4) ext_clk_in <= ~ext_clk_in;
      if (cyc_cnt == LIMIT) begin
         error_cnt++;
         give_verdict();
      end
   end

   // Prints the verdict and ends the run
   task automatic give_verdict();
      if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Compares a seen value with the expected one
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle register read, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask

   // Counter snapshot; a carry between the byte reads takes the new high byte
   task automatic rd_cnt(output logic [15:0] v);
      logic [7:0] h;
      rd(`TOC_OFS_CNT_HI, v[15:8]);
      rd(`TOC_OFS_CNT_LO, v[7:0]);
      rd(`TOC_OFS_CNT_HI, h);
      if (h != v[15:8]) v = {h, 8'h00};
   endtask

   // Waits for a pin to reach a level, returns the cycle number
   task automatic wait_lvl(input bit pin, input logic lvl, output int t);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (((pin ? p2_o : p1_o) !== lvl) && n < 3000);
      t = cyc_cnt;
      chk(16'(n < 3000), 16'h1);
   endtask

   // Reset values, unmapped read
   task automatic t_reset();
      logic [7:0] d;
      chk({timer_irq, p1_o, p1_oe, p2_o, p2_oe}, 16'h0);
      rd(`TOC_OFS_CMP1_HI, d); chk(d, 16'h80);
      @(negedge sys_clk);
      chk(reg_rdata, 16'h00); // Read data stands one cycle only
      rd(`TOC_OFS_CMP1_LO, d); chk(d, 16'h00);
      rd(`TOC_OFS_CMP2_HI, d); chk(d, 16'h80);
      rd(`TOC_OFS_CMP2_LO, d); chk(d, 16'h00);
      rd(4'hf, d); chk(d, 16'h0);
   endtask

   // Two channels 4 counts apart under every clock source
   task automatic t_match();
      logic [1:0]  sel [4] = '{2'b01, 2'b00, 2'b10, 2'b11};
      int          div [4] = '{2, 4, 8, 10};
      logic [15:0] v;
      logic [7:0]  s;
      int          t1, t2;
      for (int i = 0; i < 4; i++) begin
         wr(`TOC_OFS_CTRL_TWO, {6'b001100, sel[i]});
         wr(`TOC_OFS_CTRL_ONE, 8'h18); // Force both pins low
         repeat (2) @(posedge sys_clk);
         chk({p1_o, p2_o, p1_oe, p2_oe}, 16'h3);
         rd_cnt(v);
         v = v + 16'h0030;
         wr(`TOC_OFS_CMP1_HI, v[15:8]);
         wr(`TOC_OFS_CMP2_HI, 8'(((v + 16'h4) >> 8)));
         rd(`TOC_OFS_STATUS, s);
         wr(`TOC_OFS_CMP1_LO, v[7:0]);
         wr(`TOC_OFS_CMP2_LO, 8'(v + 16'h4));
         rd(`TOC_OFS_STATUS, s); chk(s & 8'h03, 16'h0);
         wr(`TOC_OFS_CTRL_ONE, 8'h03);
         wait_lvl(1'b0, 1'b1, t1);
         wait_lvl(1'b1, 1'b1, t2);
         chk(16'(t2 - t1), 16'(4 * div[i]));
         rd(`TOC_OFS_STATUS, s); chk(s & 8'h03, 16'h3);
      end
   endtask

   // Compare interrupt with its enable set, gated by the CPU mask
   task automatic t_irq();
      logic [7:0] d;
      wr(`TOC_OFS_CTRL_TWO, 8'h31);
      wr(`TOC_OFS_CTRL_ONE, 8'h83);
      repeat (3) @(posedge sys_clk);
      chk(timer_irq, 16'h0);
      cpu_irq_mask <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(timer_irq, 16'h1);
      rd(`TOC_OFS_CMP1_LO, d);
      rd(`TOC_OFS_CMP2_LO, d);
      repeat (3) @(posedge sys_clk);
      chk(timer_irq, 16'h0);
   endtask

   // High byte interlock, disabled pin, two-step clear
   task automatic t_inhibit();
      logic [15:0] v;
      logic [7:0]  s;
      wr(`TOC_OFS_CTRL_TWO, 8'h01);
      rd_cnt(v);
      v = v + 16'h0030;
      wr(`TOC_OFS_CMP1_HI, v[15:8]);
      wr(`TOC_OFS_CMP1_LO, v[7:0]);
      wr(`TOC_OFS_CMP1_HI, v[15:8]); // Interlock left armed
      repeat (130) @(posedge sys_clk);
      rd(`TOC_OFS_STATUS, s); chk(s[0], 16'h0);
      rd_cnt(v);
      v = v + 16'h0030;
      wr(`TOC_OFS_CMP1_HI, v[15:8]);
      wr(`TOC_OFS_CMP1_LO, v[7:0]);
      repeat (130) @(posedge sys_clk);
      chk(p1_oe, 16'h0);
      chk(timer_irq, 16'h1);
      rd(`TOC_OFS_CMP1_LO, s); // Not armed: must not clear
      rd(`TOC_OFS_STATUS, s); chk(s[0], 16'h1);
      rd(`TOC_OFS_CMP1_LO, s);
      rd(`TOC_OFS_STATUS, s); chk(s[0], 16'h0);
   endtask

   // One pulse mode: trigger, pulse length, flags, force, equal levels
   task automatic t_pulse();
      logic [15:0] v;
      logic [7:0]  s;
      int          t1, t2;
      wr(`TOC_OFS_CTRL_TWO, 8'h11);
      wr(`TOC_OFS_CTRL_ONE, 8'h08);
      wr(`TOC_OFS_CMP1_HI, 8'h00);
      wr(`TOC_OFS_CMP1_LO, 8'h10);
      wr(`TOC_OFS_CTRL_ONE, 8'h46);
      wr(`TOC_OFS_CTRL_TWO, 8'h15);
      cap_in <= 1'b1;
      wait_lvl(1'b0, 1'b1, t1);
      wait_lvl(1'b0, 1'b0, t2);
      chk(16'(t2 - t1 >= 38 && t2 - t1 <= 46), 16'h1);
      chk(timer_irq, 16'h1);
      rd(`TOC_OFS_STATUS, s); chk(s & 8'h05, 16'h4);
      rd(`TOC_OFS_CAP1_HI, v[15:8]);
      rd(`TOC_OFS_CAP1_LO, v[7:0]);
      chk(v, 16'hfffd);
      rd(`TOC_OFS_STATUS, s); chk(s[2], 16'h0);
      wr(`TOC_OFS_CTRL_ONE, 8'h4f); // Force with both levels high
      repeat (3) @(posedge sys_clk);
      chk(p1_o, 16'h0);
      cap_in <= 1'b0;
      repeat (3) @(posedge sys_clk);
      cap_in <= 1'b1;
      wait_lvl(1'b0, 1'b1, t1);
      repeat (60) @(posedge sys_clk);
      chk(p1_o, 16'h1);
      // PWM bit beside the pulse select: an edge must not trigger
      wr(`TOC_OFS_CTRL_TWO, 8'h1d);
      rd(`TOC_OFS_STATUS, s);
      rd(`TOC_OFS_CAP1_LO, s);
      @(posedge sys_clk);
      cap_in <= 1'b0;
      repeat (3) @(posedge sys_clk);
      cap_in <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(`TOC_OFS_STATUS, s); chk(s[2], 16'h0);
   endtask

   // Reset in mid-run: pin 1 and its enable low, compare value 1 low byte back to 00h
   task automatic t_rst_mid();
      logic [7:0] d;
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({timer_irq, p1_o, p1_oe}, 16'h0);
      @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      rd(`TOC_OFS_CMP1_LO, d); chk(d, 16'h00);
   endtask

   // Main sequence
   initial begin
      rst_b = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cpu_irq_mask = 1'b1;
      ext_clk_in = 1'b0;
      ext_div = 3'h0;
      cap_in = 1'b0;
      cyc_cnt = 0;
      error_cnt = 0;
      num_checks = 0;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      t_reset();
      t_match();
      t_irq();
      t_inhibit();
      t_pulse();
      t_rst_mid();
      give_verdict();
   end
endmodule // testbench
